// >>> logic/iirc_pin_sync.sv
// Bus line synchroniser and STOP condition detector
`timescale 1ns/100ps
module iirc_pin_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Bus line levels from the pads
	input  wire logic sclIn,
	input  wire logic sdaIn,
	// Filtered levels and STOP event
	output logic      sclLevel,
	output logic      sdaLevel,
	output logic      stopPulse
);
	logic [2:0] sclSync_r;
	logic [2:0] sdaSync_r;
	logic       sclLevel_r;
	logic       sdaLevel_r;
	logic       stop_r;

	// ----------------------------------------------------------------
	// Three-stage synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclSync_r <= 3'h7;
			sdaSync_r <= 3'h7;
		end else begin
			sclSync_r <= {sclSync_r[1:0], sclIn};
			sdaSync_r <= {sdaSync_r[1:0], sdaIn};
		end
	end

	// ----------------------------------------------------------------
	// Accept a level once stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclLevel_r <= 1'b1;
			sdaLevel_r <= 1'b1;
			stop_r     <= 1'b0;
		end else begin
			if (sclSync_r[1] == sclSync_r[2]) begin
				sclLevel_r <= sclSync_r[2];
			end
			if (sdaSync_r[1] == sdaSync_r[2]) begin
				sdaLevel_r <= sdaSync_r[2];
			end
			// Data rising while clock high
			stop_r <= (sdaSync_r[1] == sdaSync_r[2]) && sdaSync_r[2] && !sdaLevel_r
				&& sclLevel_r;
		end
	end

	assign sclLevel  = sclLevel_r;
	assign sdaLevel  = sdaLevel_r;
	assign stopPulse = stop_r;
endmodule

// >>> logic/iirc_pkg.sv
// Constants of the I2C interrupt and reset control block
// Summary of operation
// - Seven events each set own status flag
// - Enable bit gates each flag's request
// - One arbiter yields single basic request
// - Separate basic and FIFO interrupt outputs
// - Source read clears the reported flag unless it is a ready or regs consumed flag
// - Ready and regs consumed flags clear by writing one, not by source read
// - Arbiter reloads next pending code after read
// - Tx ready set on shift register load
// - Rx ready set on receive buffer load
// - Regs consumed set when values used
// - No-ack set when slave fails acknowledge
// - Arbitration lost set on lost contest
// - Stop seen set on any STOP
// - Slave addressed set when addressed by master
// - Tx FIFO interrupt at threshold up to 4
// - Rx FIFO interrupt at threshold up to 4
// - FIFO requests ORed, separate status flags
// - Enable bit 0 clears flags, releases lines
// - Chip reset defaults registers, enable 0
// - Shift registers internal, others CPU visible
// - Enable bit 1 lets engine requests drive bus lines low
package iirc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_OWN_ADDR   = 16'h7900;
	localparam logic [15:0] IDX_IRQ_EN     = 16'h7901;
	localparam logic [15:0] IDX_STATUS     = 16'h7902;
	localparam logic [15:0] IDX_SCL_LOW    = 16'h7903;
	localparam logic [15:0] IDX_SCL_HIGH   = 16'h7904;
	localparam logic [15:0] IDX_BYTE_CNT   = 16'h7905;
	localparam logic [15:0] IDX_RX_BUF     = 16'h7906;
	localparam logic [15:0] IDX_TGT_ADDR   = 16'h7907;
	localparam logic [15:0] IDX_TX_BUF     = 16'h7908;
	localparam logic [15:0] IDX_MODE       = 16'h7909;
	localparam logic [15:0] IDX_IRQ_SRC    = 16'h790a;
	localparam logic [15:0] IDX_PRESCALE   = 16'h790c;
	localparam logic [15:0] IDX_TX_FIFO    = 16'h7920;
	localparam logic [15:0] IDX_RX_FIFO    = 16'h7921;

	// ----------------------------------------------------------------
	// Event numbering, also status bit order and priority order
	// ----------------------------------------------------------------
	localparam int NUM_EVENTS = 7;
	localparam int EV_ARB_LOST  = 0;
	localparam int EV_NO_ACK    = 1;
	localparam int EV_REGS_USED = 2;
	localparam int EV_RX_READY  = 3;
	localparam int EV_TX_READY  = 4;
	localparam int EV_STOP_SEEN = 5;
	localparam int EV_SLAVE_ADR = 6;

	// Status bit positions of each event
	localparam int STAT_POS_ARB_LOST  = 0;
	localparam int STAT_POS_NO_ACK    = 1;
	localparam int STAT_POS_REGS_USED = 2;
	localparam int STAT_POS_RX_READY  = 3;
	localparam int STAT_POS_TX_READY  = 4;
	localparam int STAT_POS_STOP_SEEN = 5;
	localparam int STAT_POS_SLAVE_ADR = 9;

	// Event mask of the flags that a source read leaves set
	localparam logic [NUM_EVENTS-1:0] KEEP_ON_SRC_READ = 7'h1c;
	localparam logic [NUM_EVENTS-1:0] FLAGS_DEFAULT    = 7'h00;

	// Source codes
	localparam logic [2:0] SRC_NONE = 3'h0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_POS_ENABLE = 5;
	localparam int FIFO_THR_LSB    = 0;
	localparam int FIFO_THR_MSB    = 2;
	localparam int FIFO_POS_CLEAR  = 6;
	localparam int FIFO_POS_FLAG   = 7;
	localparam int FIFO_POS_IRQEN  = 5;
	localparam int FIFO_LVL_LSB    = 8;
	localparam int FIFO_LVL_MSB    = 10;
	localparam logic [2:0] FIFO_MAX_THR = 3'h4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] REG_RESET      = 16'h0000;
	localparam logic [15:0] FIFO_CTL_MASK  = 16'h0027;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// >>> logic/iirc_top.sv
// Interrupt aggregation, module reset and register file of the I2C controller
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module iirc_top
	import iirc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Event pulses from the protocol engine
	input  wire logic        txShiftLoaded,
	input  wire logic        rxBufferLoaded,
	input  wire logic        regsConsumed,
	input  wire logic        noAckSeen,
	input  wire logic        arbLost,
	input  wire logic        slaveAddressed,
	input  wire logic [15:0] rxData,
	// FIFO levels from the FIFO engine
	input  wire logic [2:0]  txFifoLevel,
	input  wire logic [2:0]  rxFifoLevel,
	// Protocol engine line drive requests
	input  wire logic        coreSclLow,
	input  wire logic        coreSdaLow,
	// Bus lines
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sclOut,
	output logic             sclOe_n,
	output logic             sdaOut,
	output logic             sdaOe_n,
	// Interrupt lines and engine enable
	output logic             basic_irq_line,
	output logic             fifo_irq_line,
	output logic             moduleEnabled
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [15:0]           regOwnAddr_r;
	logic [15:0]           regIrqEn_r;
	logic [15:0]           regSclLow_r;
	logic [15:0]           regSclHigh_r;
	logic [15:0]           regByteCnt_r;
	logic [15:0]           regTgtAddr_r;
	logic [15:0]           regTxBuf_r;
	logic [15:0]           regMode_r;
	logic [15:0]           regPrescale_r;
	logic [15:0]           regTxFifo_r;
	logic [15:0]           regRxFifo_r;
	logic [NUM_EVENTS-1:0] flags_r;
	logic [NUM_EVENTS-1:0] flags_nxt;
	logic [NUM_EVENTS-1:0] evSet;
	logic [NUM_EVENTS-1:0] evClr;
	logic [NUM_EVENTS-1:0] enMask;
	logic [2:0]            srcCode_r;
	logic [2:0]            srcCode_nxt;
	logic                  txFifoFlag_r;
	logic                  rxFifoFlag_r;
	logic                  basicIrq_r;
	logic                  fifoIrq_r;
	logic                  enable;
	logic                  wrPend_r;
	logic [15:0]           wrIdx_r;
	logic                  rdTake;
	logic                  wrTake;
	logic [15:0]           busIdx;
	logic                  wrData;
	logic [31:0]           hrdata_r;
	logic                  hreadyout_r;
	logic                  hresp_r;
	logic                  sclOut_r;
	logic                  sclOe_n_r;
	logic                  sdaOut_r;
	logic                  sdaOe_n_r;
	logic                  sclLevel;
	logic                  sdaLevel;
	logic                  stopPulse;
	logic                  txThrHit;
	logic                  rxThrHit;

	// Status bit position of an event
	function automatic int statPos(input int ev);
		case (ev)
			EV_ARB_LOST:  statPos = STAT_POS_ARB_LOST;
			EV_NO_ACK:    statPos = STAT_POS_NO_ACK;
			EV_REGS_USED: statPos = STAT_POS_REGS_USED;
			EV_RX_READY:  statPos = STAT_POS_RX_READY;
			EV_TX_READY:  statPos = STAT_POS_TX_READY;
			EV_STOP_SEEN: statPos = STAT_POS_STOP_SEEN;
			default:      statPos = STAT_POS_SLAVE_ADR;
		endcase
	endfunction

	// Gather the seven events from a status layout word
	function automatic logic [NUM_EVENTS-1:0] fromStat(input logic [15:0] w);
		fromStat = '0;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			fromStat[i] = w[statPos(i)];
		end
	endfunction

	// Spread the seven events into the status layout word
	function automatic logic [15:0] toStat(input logic [NUM_EVENTS-1:0] f);
		toStat = '0;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			toStat[statPos(i)] = f[i];
		end
	endfunction

	// ----------------------------------------------------------------
	// Bus line sampling
	// ----------------------------------------------------------------
	iirc_pin_sync u_pin_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.sclIn     (sclIn),
		.sdaIn     (sdaIn),
		.sclLevel  (sclLevel),
		.sdaLevel  (sdaLevel),
		.stopPulse (stopPulse)
	);

	// ----------------------------------------------------------------
	// AHB-Lite decode
	// ----------------------------------------------------------------
	assign busIdx = haddr[17:2];
	assign rdTake = hsel && hready && !hwrite && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign wrTake = hsel && hready && hwrite && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign wrData = wrPend_r;
	assign enable = regMode_r[MODE_POS_ENABLE];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend_r    <= 1'b0;
			wrIdx_r     <= 16'h0000;
			hreadyout_r <= 1'b1;
		end else begin
			wrPend_r    <= wrTake;
			hreadyout_r <= 1'b1;
			if (wrTake) begin
				wrIdx_r <= busIdx;
			end
		end
	end

	// Response is always OKAY, held in a flop like every other output
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hresp_r <= HRESP_OKAY;
		end else begin
			hresp_r <= HRESP_OKAY;
		end
	end

	// Read data, unmapped and write-only bits read as zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata_r <= 32'h00000000;
		end else if (rdTake) begin
			case (busIdx)
				IDX_OWN_ADDR: hrdata_r <= {16'h0000, regOwnAddr_r};
				IDX_IRQ_EN:   hrdata_r <= {16'h0000, toStat(enMask)};
				IDX_STATUS:   hrdata_r <= {16'h0000, toStat(flags_r)};
				IDX_SCL_LOW:  hrdata_r <= {16'h0000, regSclLow_r};
				IDX_SCL_HIGH: hrdata_r <= {16'h0000, regSclHigh_r};
				IDX_BYTE_CNT: hrdata_r <= {16'h0000, regByteCnt_r};
				IDX_RX_BUF:   hrdata_r <= {16'h0000, rxData};
				IDX_TGT_ADDR: hrdata_r <= {16'h0000, regTgtAddr_r};
				IDX_TX_BUF:   hrdata_r <= {16'h0000, regTxBuf_r};
				IDX_MODE:     hrdata_r <= {16'h0000, regMode_r};
				IDX_IRQ_SRC:  hrdata_r <= {29'h00000000, srcCode_r};
				IDX_PRESCALE: hrdata_r <= {16'h0000, regPrescale_r};
				IDX_TX_FIFO:  hrdata_r <= {16'h0000, 5'h00, txFifoLevel, txFifoFlag_r,
					regTxFifo_r[6:0]};
				IDX_RX_FIFO:  hrdata_r <= {16'h0000, 5'h00, rxFifoLevel, rxFifoFlag_r,
					regRxFifo_r[6:0]};
				default:      hrdata_r <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control registers, all defaulted by chip reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regOwnAddr_r  <= REG_RESET;
			regIrqEn_r    <= REG_RESET;
			regSclLow_r   <= REG_RESET;
			regSclHigh_r  <= REG_RESET;
			regByteCnt_r  <= REG_RESET;
			regTgtAddr_r  <= REG_RESET;
			regTxBuf_r    <= REG_RESET;
			regMode_r     <= REG_RESET;
			regPrescale_r <= REG_RESET;
			regTxFifo_r   <= REG_RESET;
			regRxFifo_r   <= REG_RESET;
		end else begin
			regTxFifo_r[FIFO_POS_CLEAR] <= 1'b0;
			regRxFifo_r[FIFO_POS_CLEAR] <= 1'b0;
			if (wrData) begin
				case (wrIdx_r)
					IDX_OWN_ADDR: regOwnAddr_r  <= hwdata[15:0];
					IDX_IRQ_EN:   regIrqEn_r    <= hwdata[15:0];
					IDX_SCL_LOW:  regSclLow_r   <= hwdata[15:0];
					IDX_SCL_HIGH: regSclHigh_r  <= hwdata[15:0];
					IDX_BYTE_CNT: regByteCnt_r  <= hwdata[15:0];
					IDX_TGT_ADDR: regTgtAddr_r  <= hwdata[15:0];
					IDX_TX_BUF:   regTxBuf_r    <= hwdata[15:0];
					IDX_MODE:     regMode_r     <= hwdata[15:0] & 16'hefff;
					IDX_PRESCALE: regPrescale_r <= hwdata[15:0];
					IDX_TX_FIFO:  regTxFifo_r   <= (hwdata[15:0] & FIFO_CTL_MASK)
						| {9'h000, hwdata[FIFO_POS_CLEAR], 6'h00};
					IDX_RX_FIFO:  regRxFifo_r   <= (hwdata[15:0] & FIFO_CTL_MASK)
						| {9'h000, hwdata[FIFO_POS_CLEAR], 6'h00};
					default:      regPrescale_r <= regPrescale_r;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Event flags
	// ----------------------------------------------------------------
	assign enMask = fromStat(regIrqEn_r);

	always_comb begin
		evSet = '0;
		evSet[EV_TX_READY]  = txShiftLoaded;
		evSet[EV_RX_READY]  = rxBufferLoaded;
		evSet[EV_REGS_USED] = regsConsumed;
		evSet[EV_NO_ACK]    = noAckSeen;
		evSet[EV_ARB_LOST]  = arbLost;
		evSet[EV_STOP_SEEN] = stopPulse;
		evSet[EV_SLAVE_ADR] = slaveAddressed;
	end

	always_comb begin
		evClr = '0;
		if (wrData && wrIdx_r == IDX_STATUS) begin
			evClr = fromStat(hwdata[15:0]);
		end
		if (rdTake && busIdx == IDX_IRQ_SRC && srcCode_r != SRC_NONE) begin
			for (int i = 0; i < NUM_EVENTS; i++) begin
				if (srcCode_r == 3'(i + 1) && !KEEP_ON_SRC_READ[i]) begin
					evClr[i] = 1'b1;
				end
			end
		end
	end

	// Set wins over a clear in the same cycle
	assign flags_nxt = (flags_r & ~evClr) | evSet;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_r <= FLAGS_DEFAULT;
		end else if (!enable) begin
			flags_r <= FLAGS_DEFAULT;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Priority arbiter, lowest event number wins
	// ----------------------------------------------------------------
	always_comb begin
		srcCode_nxt = SRC_NONE;
		for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
			if (flags_nxt[i] && enMask[i]) begin
				srcCode_nxt = 3'(i + 1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			srcCode_r  <= SRC_NONE;
			basicIrq_r <= 1'b0;
		end else begin
			srcCode_r  <= srcCode_nxt;
			basicIrq_r <= |(flags_nxt & enMask);
		end
	end

	// ----------------------------------------------------------------
	// FIFO threshold interrupts
	// ----------------------------------------------------------------
	assign txThrHit = txFifoLevel <= regTxFifo_r[FIFO_THR_MSB:FIFO_THR_LSB]
		&& regTxFifo_r[FIFO_THR_MSB:FIFO_THR_LSB] <= FIFO_MAX_THR;
	assign rxThrHit = rxFifoLevel >= regRxFifo_r[FIFO_THR_MSB:FIFO_THR_LSB]
		&& regRxFifo_r[FIFO_THR_MSB:FIFO_THR_LSB] <= FIFO_MAX_THR
		&& regRxFifo_r[FIFO_THR_MSB:FIFO_THR_LSB] != 3'h0;

	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			txFifoFlag_r <= 1'b0;
			rxFifoFlag_r <= 1'b0;
			fifoIrq_r    <= 1'b0;
		end else begin
			txFifoFlag_r <= txThrHit || (txFifoFlag_r && !regTxFifo_r[FIFO_POS_CLEAR]);
			rxFifoFlag_r <= rxThrHit || (rxFifoFlag_r && !regRxFifo_r[FIFO_POS_CLEAR]);
			fifoIrq_r    <= (txFifoFlag_r && regTxFifo_r[FIFO_POS_IRQEN])
				|| (rxFifoFlag_r && regRxFifo_r[FIFO_POS_IRQEN]);
		end
	end

	// ----------------------------------------------------------------
	// Bus line drive, released while the module is disabled
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclOut_r  <= 1'b0;
			sclOe_n_r <= 1'b1;
			sdaOut_r  <= 1'b0;
			sdaOe_n_r <= 1'b1;
		end else begin
			sclOut_r  <= 1'b0;
			sdaOut_r  <= 1'b0;
			sclOe_n_r <= !(enable && coreSclLow);
			sdaOe_n_r <= !(enable && coreSdaLow);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hrdata         = hrdata_r;
	assign hreadyout      = hreadyout_r;
	assign hresp          = hresp_r;
	assign sclOut         = sclOut_r;
	assign sclOe_n        = sclOe_n_r;
	assign sdaOut         = sdaOut_r;
	assign sdaOe_n        = sdaOe_n_r;
	assign basic_irq_line = basicIrq_r;
	assign fifo_irq_line  = fifoIrq_r;
	assign moduleEnabled  = regMode_r[MODE_POS_ENABLE];
endmodule

// >>> test/iirc_bus_model.sv
// Bus partner: pull-ups and a second party on the two bus lines
`timescale 1ns/100ps
module iirc_bus_model (
	// Design side
	input  wire logic sclOe_n,
	input  wire logic sdaOe_n,
	// Wire levels
	output logic      scl,
	output logic      sda
);
	logic mScl = 1'b1;
	logic mSda = 1'b1;

	// Wired-AND with pull-ups: a released line reads high
	assign scl = mScl & sclOe_n;
	assign sda = mSda & sdaOe_n;

	// Short frame at a 200 ns link period: start, two clocks, stop
	task automatic frame();
		mSda = 1'b0;
		#100 mScl = 1'b0;
		repeat (2) begin
			#100 mScl = 1'b1;
			#100 mScl = 1'b0;
		end
		#100 mScl = 1'b1;
		#100 mSda = 1'b1;
		#400;
	endtask
endmodule

// >>> test/iirc_checker.sv
// Assertion checker for the interrupt and reset control block
`timescale 1ns/100ps
module iirc_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Bus answer
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Line requests and lines
	input wire logic        coreSclLow,
	input wire logic        coreSdaLow,
	input wire logic        sclOut,
	input wire logic        sclOe_n,
	input wire logic        sdaOut,
	input wire logic        sdaOe_n,
	// Interrupts and enable
	input wire logic        basic_irq_line,
	input wire logic        fifo_irq_line,
	input wire logic        moduleEnabled
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_READY_OKAY: assert property (hreadyout && hresp == 1'b0)
		else $error("bus slave stalled or answered with an error");
	AST_UPPER_ZERO: assert property (hrdata[31:16] == 16'h0000)
		else $error("upper read data bits not zero");
	AST_RESET_DEFAULT: assert property ($rose(rst_n) |-> !moduleEnabled && !basic_irq_line
		&& !fifo_irq_line && sclOe_n && sdaOe_n)
		else $error("outputs not at defaults after reset");
	AST_OFF_RELEASE: assert property (!moduleEnabled && !$past(moduleEnabled)
		|-> sclOe_n && sdaOe_n)
		else $error("line driven while module disabled");
	AST_OFF_QUIET: assert property (!moduleEnabled && !$past(moduleEnabled)
		|-> !basic_irq_line && !fifo_irq_line)
		else $error("interrupt raised while module disabled");
	AST_SCL_FOLLOW: assert property (moduleEnabled && $past(moduleEnabled)
		|-> sclOe_n == !$past(coreSclLow))
		else $error("clock line enable does not follow request");
	AST_SDA_FOLLOW: assert property (moduleEnabled && $past(moduleEnabled)
		|-> sdaOe_n == !$past(coreSdaLow))
		else $error("data line enable does not follow request");
	AST_DRIVE_ZERO: assert property ((!sclOe_n || !sdaOe_n) |-> !(sclOut || sdaOut))
		else $error("line driven high");
	AST_IRQ_NEEDS_EN: assert property (basic_irq_line |-> $past(moduleEnabled))
		else $error("basic interrupt while disabled");

	// ------------------------------------------------------------
	// Coverage
	// ------------------------------------------------------------
	COV_IRQ: cover property ($rose(basic_irq_line));
	COV_FIFO: cover property ($rose(fifo_irq_line));
	COV_OFF: cover property ($fell(moduleEnabled));
endmodule

bind iirc_top iirc_checker chk_i (.*);

// >>> test/iirc_top_tb.sv
// Self-checking bench of the interrupt and reset control block
`timescale 1ns/100ps
module iirc_top_tb;
	import iirc_pkg::*;
	typedef struct {int ev; int pos; logic [31:0] code; bit keep;} iirc_row_t;
	iirc_row_t   rows [6] = '{'{0, 0, 1, 0}, '{1, 1, 2, 0}, '{2, 2, 3, 1},
		'{3, 3, 4, 1}, '{4, 4, 5, 1}, '{5, 9, 7, 0}};
	logic        clk, rst_n, hsel, hwrite, coreSclLow, coreSdaLow;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0]  htrans;
	logic [2:0]  hsize, txLvl, rxLvl;
	logic [5:0]  ev;
	logic [15:0] rxData;
	logic        hreadyout, hresp, sclIn, sdaIn, sclOe_n, sdaOe_n;
	logic        basic_irq_line, fifo_irq_line, moduleEnabled;
	int          error_cnt = 0;
	int          checks_done = 0;

	iirc_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txShiftLoaded(ev[4]),
		.rxBufferLoaded(ev[3]), .regsConsumed(ev[2]), .noAckSeen(ev[1]), .arbLost(ev[0]),
		.slaveAddressed(ev[5]), .rxData(rxData), .txFifoLevel(txLvl), .rxFifoLevel(rxLvl),
		.coreSclLow(coreSclLow), .coreSdaLow(coreSdaLow), .sclIn(sclIn), .sdaIn(sdaIn),
		.sclOut(), .sclOe_n(sclOe_n), .sdaOut(), .sdaOe_n(sdaOe_n),
		.basic_irq_line(basic_irq_line), .fifo_irq_line(fifo_irq_line),
		.moduleEnabled(moduleEnabled));
	iirc_bus_model link (.sclOe_n(sclOe_n), .sdaOe_n(sdaOe_n), .scl(sclIn), .sda(sdaIn));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic waitFor(input int which, input logic val);
		int n;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if ((which == 0 ? hreadyout : which == 1 ? basic_irq_line : fifo_irq_line) === val) begin
				return;
			end
		end
		error_cnt++;
		end_sim();
	endtask
	task automatic bus(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		waitFor(0, 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitFor(0, 1'b1);
		rdv = hrdata;
	endtask
	task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
		bus(idx, 1'b0, 32'h0);
		chk(rdv, exp);
	endtask
	task automatic pulse(input logic [5:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 6'h00;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h0; ev = 6'h00; rxData = 16'h5a3c;
		txLvl = 3'h3; rxLvl = 3'h3; coreSclLow = 1'b0; coreSdaLow = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(IDX_MODE, 32'h0);
		rd(IDX_IRQ_EN, 32'h0);
		chk({31'h0, basic_irq_line}, 32'h0);
		bus(IDX_IRQ_EN, 1'b1, 32'h023f);
		rd(IDX_IRQ_EN, 32'h023f);
		bus(IDX_OWN_ADDR, 1'b1, 32'h1234);
		rd(IDX_OWN_ADDR, 32'h1234);
		bus(IDX_RX_BUF, 1'b1, 32'hffff);
		rd(IDX_RX_BUF, 32'h5a3c);
		rd(16'h790b, 32'h0);
		chk({31'h0, moduleEnabled}, 32'h0);
		bus(IDX_MODE, 1'b1, 32'h1020);
		rd(IDX_MODE, 32'h0020);
		chk({31'h0, moduleEnabled}, 32'h1);
		foreach (rows[i]) begin
			pulse(6'h01 << rows[i].ev);
			rd(IDX_STATUS, 32'h1 << rows[i].pos);
			chk({31'h0, basic_irq_line}, 32'h1);
			rd(IDX_IRQ_SRC, rows[i].code);
			rd(IDX_STATUS, rows[i].keep ? 32'h1 << rows[i].pos : 32'h0);
			bus(IDX_STATUS, 1'b1, 32'h1 << rows[i].pos);
			rd(IDX_STATUS, 32'h0);
			chk({31'h0, basic_irq_line}, 32'h0);
		end
		link.frame();
		waitFor(1, 1'b1);
		rd(IDX_STATUS, 32'h0020);
		rd(IDX_IRQ_SRC, 32'h6);
		rd(IDX_STATUS, 32'h0);
		pulse(6'h23);
		rd(IDX_IRQ_SRC, 32'h1);
		rd(IDX_IRQ_SRC, 32'h2);
		rd(IDX_IRQ_SRC, 32'h7);
		rd(IDX_IRQ_SRC, 32'h0);
		chk({31'h0, basic_irq_line}, 32'h0);
		bus(IDX_IRQ_EN, 1'b1, 32'h0);
		pulse(6'h02);
		rd(IDX_STATUS, 32'h0002);
		chk({31'h0, basic_irq_line}, 32'h0);
		bus(IDX_IRQ_EN, 1'b1, 32'h0002);
		waitFor(1, 1'b1);
		rd(IDX_IRQ_SRC, 32'h2);
		chk({31'h0, basic_irq_line}, 32'h0);
		bus(IDX_TX_FIFO, 1'b1, 32'h0022);
		chk({31'h0, fifo_irq_line}, 32'h0);
		@(posedge clk) txLvl <= 3'h2;
		waitFor(2, 1'b1);
		rd(IDX_TX_FIFO, 32'h02a2);
		@(posedge clk) txLvl <= 3'h3;
		bus(IDX_TX_FIFO, 1'b1, 32'h0062);
		rd(IDX_TX_FIFO, 32'h0322);
		waitFor(2, 1'b0);
		bus(IDX_RX_FIFO, 1'b1, 32'h0024);
		chk({31'h0, fifo_irq_line}, 32'h0);
		@(posedge clk) rxLvl <= 3'h4;
		waitFor(2, 1'b1);
		rd(IDX_RX_FIFO, 32'h04a4);
		pulse(6'h01);
		@(posedge clk);
		coreSclLow <= 1'b1;
		coreSdaLow <= 1'b1;
		rd(IDX_STATUS, 32'h0001);
		chk({31'h0, sclOe_n}, 32'h0);
		chk({31'h0, sdaOe_n}, 32'h0);
		bus(IDX_MODE, 1'b1, 32'h0);
		rd(IDX_STATUS, 32'h0);
		chk({31'h0, basic_irq_line}, 32'h0);
		chk({31'h0, fifo_irq_line}, 32'h0);
		chk({31'h0, sclOe_n}, 32'h1);
		chk({31'h0, sdaOe_n}, 32'h1);
		chk({31'h0, moduleEnabled}, 32'h0);
		bus(IDX_MODE, 1'b1, 32'h0020);
		rd(IDX_STATUS, 32'h0);
		chk({31'h0, sclOe_n}, 32'h0);
		// Chip reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		chk({31'h0, moduleEnabled}, 32'h0);
		rd(IDX_IRQ_EN, 32'h0);
		rd(IDX_RX_FIFO, 32'h0400);
		chk({31'h0, sclOe_n}, 32'h1);
		end_sim();
	end
endmodule
